// ### rtl/tpg_gate_input.sv
// three phase gate input logic: command pins, enable gate, serial port, phase levels
// Functional notes
// - Gate outputs turn on only while both enable inputs are high.
// - A low level on a phase high-side command turns that high-side driver on.
// - A high level on a phase low-side command turns that low-side driver on.
// - Serial data arrives most significant bit first, sampled on the falling serial clock edge.
// - Serial output stays released while chip select is high and drives only after it falls.
// - Chip select bounds each command; serial traffic counts only while it is low.
// - Each phase level output is low while its source node is below half the load supply.
// - Dead time between high-side and low-side switching is set by serial command.
`timescale 1ns/10ps
`include "tpg_params.svh"
module tpg_gate_input
  import tpg_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic enable_in_a,
  input  wire logic enable_in_b,
  input  wire logic phase_a_high_cmd_n,
  input  wire logic phase_b_high_cmd_n,
  input  wire logic phase_c_high_cmd_n,
  input  wire logic phase_a_low_cmd,
  input  wire logic phase_b_low_cmd,
  input  wire logic phase_c_low_cmd,
  input  wire logic phase_a_high_source_below_half,
  input  wire logic phase_b_high_source_below_half,
  input  wire logic phase_c_high_source_below_half,
  input  wire logic spi_cs_n,
  input  wire logic spi_sclk,
  input  wire logic spi_si,
  output logic      spi_so,
  output logic      spi_so_oe_n,
  output logic      phase_a_level_out,
  output logic      phase_b_level_out,
  output logic      phase_c_level_out,
  output logic      gate_a_high,
  output logic      gate_b_high,
  output logic      gate_c_high,
  output logic      gate_a_low,
  output logic      gate_b_low,
  output logic      gate_c_low
);
  localparam int NSYNC = 13;
  // idle level of each synchronised pin, so nothing seems to move when reset lifts;
  // any other value would fake a chip select or a serial clock edge just after reset
  localparam logic [NSYNC-1:0] PIN_IDLE = `TPG_PIN_IDLE;

  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  logic [NSYNC-1:0] sync3;
  logic [NSYNC-1:0] clean;
  logic             enable;
  logic [2:0]       want_high;
  logic [2:0]       want_low;
  logic [2:0]       gate_high;
  logic [2:0]       gate_low;
  logic             cs_n;
  logic             sclk;
  logic             sclk_prev;
  logic             sclk_fall;
  logic             sclk_rise;
  logic [`TPG_FRAME_BITS-1:0] shift_in;
  logic [`TPG_FRAME_BITS-1:0] shift_out;
  logic [3:0]       bit_cnt;
  logic [`TPG_DEAD_WIDTH-1:0] dead_units;
  logic             simultaneous;
  logic             frame_ok;

  // synchroniser bank layout:
  //   [0]     both enables, already combined
  //   [3:1]   high-side commands, active low
  //   [6:4]   low-side commands, active high
  //   [9:7]   chip select, serial clock, serial data in
  //   [12:10] comparator inputs, high while the source node is below half supply
  // the enables are combined before the flops; a one-clock glitch of the product
  // never gets past the agreement filter, so no gate can blip on
  assign raw_in = {phase_c_high_source_below_half, phase_b_high_source_below_half,
                   phase_a_high_source_below_half, spi_si, spi_sclk, spi_cs_n,
                   phase_c_low_cmd, phase_b_low_cmd, phase_a_low_cmd,
                   phase_c_high_cmd_n, phase_b_high_cmd_n, phase_a_high_cmd_n,
                   enable_in_a & enable_in_b};

  // three stages per pin; a change is taken once the last two agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= PIN_IDLE;
      sync2 <= PIN_IDLE;
      sync3 <= PIN_IDLE;
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // per-bit agreement filter, holds old value while stages disagree
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_filt
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          clean[gi] <= PIN_IDLE[gi];
        end else if (sync2[gi] == sync3[gi]) begin
          clean[gi] <= sync3[gi];
        end
      end
    end
  endgenerate

  // decoded pin levels after the filter; command polarities are undone here
  assign enable    = clean[0];
  assign want_high = ~clean[3:1];
  assign want_low  = clean[6:4];
  assign cs_n      = clean[7];
  assign sclk      = clean[8];
  assign sclk_fall = sclk_prev && !sclk;
  assign sclk_rise = !sclk_prev && sclk;

  // a command counts only on a clean end of frame: select high again, its last synchroniser stage
  // high too, and exactly one frame of falling edges seen while it was low
  assign frame_ok = cs_n && sync3[7] && bit_cnt == 4'(`TPG_FRAME_BITS);

  // edge finder for the serial clock; a frame only counts while selected
  // the previous value resets to the idle level of the pin, so no edge is seen at reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_prev <= 1'b0;
    end else begin
      sclk_prev <= sclk;
    end
  end

  // shift register: msb first, sampled on the falling edge; the count stops at
  // fifteen so that a long frame never wraps round to the legal length
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_in <= 8'h00;
      bit_cnt  <= 4'h0;
    end else if (cs_n) begin
      bit_cnt <= 4'h0;
    end else if (sclk_fall) begin
      shift_in <= {shift_in[`TPG_FRAME_BITS-2:0], clean[9]};
      if (bit_cnt != 4'hF) begin
        bit_cnt <= bit_cnt + 4'h1;
      end
    end
  end

  // commands take effect only when chip select rises after exactly one frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dead_units   <= `TPG_DEAD_RESET;
      simultaneous <= 1'b0;
    end else if (frame_ok) begin
      // the top bit picks the command; spare bits are ignored for later codes
      if (shift_in[`TPG_CMD_POS] == `TPG_CMD_DEADTIME) begin
        dead_units <= shift_in[`TPG_DEAD_POS +: `TPG_DEAD_WIDTH];
      end else begin
        simultaneous <= shift_in[`TPG_SIM_POS];
      end
    end
  end

  // readback: status shifts out msb first, changed on rising edges
  // the word is captured while deselected, so a command never alters it mid-frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_out   <= 8'h00;
      spi_so      <= 1'b0;
      spi_so_oe_n <= 1'b1;
    end else if (cs_n) begin
      shift_out   <= {simultaneous, 1'b0, dead_units};
      spi_so_oe_n <= 1'b1;
    end else begin
      spi_so_oe_n <= 1'b0;
      spi_so      <= shift_out[`TPG_FRAME_BITS-1];
      if (sclk_rise && bit_cnt != 4'h0) begin
        shift_out <= {shift_out[`TPG_FRAME_BITS-2:0], 1'b0};
      end
    end
  end

  // comparator levels: low while the source node is below half supply
  // registered so the pins never show a glitch of the filter stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_a_level_out <= 1'b0;
      phase_b_level_out <= 1'b0;
      phase_c_level_out <= 1'b0;
    end else begin
      phase_a_level_out <= !clean[10];
      phase_b_level_out <= !clean[11];
      phase_c_level_out <= !clean[12];
    end
  end

  // one leg per phase; all three share the enable gate, the dead time and the mode
  generate
    for (gi = 0; gi < 3; gi++) begin : g_leg
      tpg_phase_leg u_leg (
        .clk          (clk),
        .rst_n        (rst_n),
        .want_high    (want_high[gi]),
        .want_low     (want_low[gi]),
        .enable       (enable),
        .simultaneous (simultaneous),
        .dead_units   (dead_units),
        .gate_high    (gate_high[gi]),
        .gate_low     (gate_low[gi])
      );
    end
  endgenerate

  // flatten the per-phase vectors onto the named gate pins
  assign gate_a_high = gate_high[0];
  assign gate_b_high = gate_high[1];
  assign gate_c_high = gate_high[2];
  assign gate_a_low  = gate_low[0];
  assign gate_b_low  = gate_low[1];
  assign gate_c_low  = gate_low[2];
endmodule

// ### rtl/tpg_params.svh
// timing counts and field positions for the three phase gate input logic
`ifndef TPG_PARAMS_SVH
`define TPG_PARAMS_SVH
`define TPG_FRAME_BITS      8
`define TPG_CMD_POS         7
`define TPG_CMD_DEADTIME    1'b0
`define TPG_CMD_MODE        1'b1
`define TPG_DEAD_POS        0
`define TPG_DEAD_WIDTH      6
`define TPG_SIM_POS         0
`define TPG_DEAD_RESET      6'h04
`define TPG_PIN_IDLE        13'h08E
`define TPG_DEAD_UNIT_NS    40
`define TPG_CLK_PERIOD_NS   40
`define TPG_DEAD_UNIT_CYC   ((`TPG_DEAD_UNIT_NS + `TPG_CLK_PERIOD_NS - 1) / `TPG_CLK_PERIOD_NS)
`endif

// ### rtl/tpg_pkg.sv
// types shared by the three phase gate input logic
package tpg_pkg;
  typedef enum logic [1:0] {
    TPG_OFF,
    TPG_DEAD,
    TPG_HIGH,
    TPG_LOW
  } tpg_leg_t;
endpackage

// ### rtl/tpg_phase_leg.sv
// one phase leg: shoot-through lockout and dead-time insertion
`timescale 1ns/10ps
`include "tpg_params.svh"
module tpg_phase_leg
  import tpg_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       want_high,
  input  wire logic       want_low,
  input  wire logic       enable,
  input  wire logic       simultaneous,
  input  wire logic [5:0] dead_units,
  output logic            gate_high,
  output logic            gate_low
);
  tpg_leg_t    state;
  logic [11:0] dead_cnt;
  logic [11:0] dead_load;

  assign dead_load = 12'(dead_units) * 12'(`TPG_DEAD_UNIT_CYC);

  // legs pass through a dead phase whenever the conducting switch changes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= TPG_OFF;
      dead_cnt <= 12'h000;
    end else begin
      unique case (state)
        TPG_OFF: begin
          if (enable && want_high && !want_low) begin
            state <= TPG_HIGH;
          end else if (enable && want_low && !want_high) begin
            state <= TPG_LOW;
          end
        end
        TPG_HIGH, TPG_LOW: begin
          // any change of command drops the leg, then waits the dead time
          if (!enable || (state == TPG_HIGH ? !want_high || want_low
                                            : !want_low || want_high)) begin
            state    <= TPG_DEAD;
            dead_cnt <= dead_load;
          end
        end
        TPG_DEAD: begin
          if (dead_cnt == 12'h000) begin
            state <= TPG_OFF;
          end else begin
            dead_cnt <= dead_cnt - 12'h001;
          end
        end
      endcase
    end
  end

  // simultaneous mode bypasses the lockout; the enable gate always applies
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_high <= 1'b0;
      gate_low  <= 1'b0;
    end else if (simultaneous) begin
      gate_high <= enable && want_high;
      gate_low  <= enable && want_low;
    end else begin
      gate_high <= enable && state == TPG_HIGH && want_high && !want_low;
      gate_low  <= enable && state == TPG_LOW && want_low && !want_high;
    end
  end
endmodule

// ### bench/tpg_gate_input_props.sv
// assertion checker for the three phase gate input logic
`timescale 1ns/10ps
module tpg_gate_input_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable_in_a,
  input wire logic enable_in_b,
  input wire logic phase_a_high_cmd_n,
  input wire logic phase_b_low_cmd,
  input wire logic phase_a_high_source_below_half,
  input wire logic spi_cs_n,
  input wire logic spi_so_oe_n,
  input wire logic phase_a_level_out,
  input wire logic gate_a_high,
  input wire logic gate_b_high,
  input wire logic gate_c_high,
  input wire logic gate_a_low,
  input wire logic gate_b_low,
  input wire logic gate_c_low
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // pin filters add about five clocks, so every repeated input window below is longer than that
  wire logic any_gate = gate_a_high | gate_b_high | gate_c_high |
                        gate_a_low | gate_b_low | gate_c_low;
  enable_gate_a: assert property (!enable_in_b [*8] |=> !any_gate)
    else $error("gate on while enable low");
  high_cmd_a: assert property ($rose(gate_a_high) |-> !$past(phase_a_high_cmd_n, 3))
    else $error("high gate on without low command");
  low_cmd_a: assert property ($rose(gate_b_low) |-> $past(phase_b_low_cmd, 3))
    else $error("low gate on without high command");
  // the bench never requests both switches of a phase while simultaneous mode is on
  no_shoot_a: assert property (
    !(gate_a_high && gate_a_low) && !(gate_b_high && gate_b_low) && !(gate_c_high && gate_c_low))
    else $error("both switches of a phase on");
  so_release_a: assert property (spi_cs_n [*6] |=> spi_so_oe_n)
    else $error("serial out driven while deselected");
  so_drive_a: assert property ($fell(spi_so_oe_n) |-> !$past(spi_cs_n, 2))
    else $error("serial out driven before select");
  level_low_a: assert property (phase_a_high_source_below_half [*7] |=> !phase_a_level_out)
    else $error("level high while node below half");
  level_high_a: assert property (
    !phase_a_high_source_below_half [*7] |=> phase_a_level_out)
    else $error("level low while node above half");
  dead_gap_a: assert property ($fell(gate_a_high) |-> !gate_a_low [*5])
    else $error("low gate on inside dead time");
  cover property ($rose(gate_a_high));
  cover property ($fell(spi_so_oe_n));
  cover property ($fell(gate_a_high) ##[1:100] gate_a_low);
endmodule
bind tpg_gate_input tpg_gate_input_props tpg_gate_input_props_inst (.*);

// ### bench/tpg_mcu_model.sv
// controller model: chip-select framed serial commands
`timescale 1ns/10ps
module tpg_mcu_model (
  output logic      spi_cs_n,
  output logic      spi_sclk,
  output logic      spi_si,
  input  wire logic spi_so
);
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_si   = 1'b0;
  end
  // clock idles low; data moves on the rise so it is steady across the sampling fall
  task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    spi_cs_n = 1'b0;
    #320;
    for (int i = nbits - 1; i >= 0; i--) begin
      spi_si = tx[i];
      spi_sclk = 1'b1;
      #160;
      spi_sclk = 1'b0;
      #150;
      rx = {rx[6:0], spi_so};
      #10;
    end
    #320;
    spi_cs_n = 1'b1;
    spi_si = ~spi_si; // no stale bit left on the line
    #640;
  endtask
endmodule

// ### bench/test_tpg_gate_input.sv
// self-checking bench for the three phase gate input logic
`timescale 1ns/10ps
`include "tpg_params.svh"
module test_tpg_gate_input;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [1:0] en = 2'b00;
  logic [2:0] hcmd_n = 3'b111;
  logic [2:0] lcmd = 3'b000;
  logic [2:0] below = 3'b000;
  logic       cs_n, sclk, si, so, so_oe_n;
  logic [2:0] lvl, gh, gl;
  logic [7:0] rx;
  logic [31:0] r;
  int         errors = 0;
  int         cmp_count = 0;
  int         seed = 32'h140C52A2;
  logic [5:0] dead = `TPG_DEAD_RESET;
  logic       sim = 1'b0;
  always #20 clk = ~clk;
  tpg_gate_input tpg_gate_input_inst (.clk(clk), .rst_n(rst_n), .enable_in_a(en[0]),
    .enable_in_b(en[1]), .phase_a_high_cmd_n(hcmd_n[0]), .phase_b_high_cmd_n(hcmd_n[1]),
    .phase_c_high_cmd_n(hcmd_n[2]), .phase_a_low_cmd(lcmd[0]), .phase_b_low_cmd(lcmd[1]),
    .phase_c_low_cmd(lcmd[2]), .phase_a_high_source_below_half(below[0]),
    .phase_b_high_source_below_half(below[1]), .phase_c_high_source_below_half(below[2]),
    .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_si(si), .spi_so(so), .spi_so_oe_n(so_oe_n),
    .phase_a_level_out(lvl[0]), .phase_b_level_out(lvl[1]), .phase_c_level_out(lvl[2]),
    .gate_a_high(gh[0]), .gate_b_high(gh[1]), .gate_c_high(gh[2]),
    .gate_a_low(gl[0]), .gate_b_low(gl[1]), .gate_c_low(gl[2]));
  tpg_mcu_model tpg_mcu_model_inst (.spi_cs_n(cs_n), .spi_sclk(sclk), .spi_si(si), .spi_so(so));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    if (errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // reference: enable gate, pin polarities, both-requested refused unless simultaneous
  function automatic logic [7:0] gates_exp();
    logic [2:0] on;
    on = {3{&en}};
    if (sim) return {2'b00, on & ~hcmd_n, on & lcmd};
    return {2'b00, on & ~hcmd_n & ~lcmd, on & lcmd & hcmd_n};
  endfunction
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  initial begin
    wait_clk(6);
    rst_n = 1'b1;
    wait_clk(4);
    check({7'h00, so_oe_n}, 8'h01);
    tpg_mcu_model_inst.xfer(8'h3F, 8, rx);
    check(rx, {2'b00, dead});
    dead = 6'h3F;
    tpg_mcu_model_inst.xfer(8'h05, 7, rx); // short frame must be dropped
    tpg_mcu_model_inst.xfer(8'h80, 8, rx);
    check(rx, {2'b00, dead});
    tpg_mcu_model_inst.xfer(8'h80, 8, rx);
    check(rx, {2'b00, dead});
    // high-to-low handover must sit out the programmed dead time
    en = 2'b11;
    hcmd_n = 3'b110;
    wait_clk(20);
    check({2'b00, gh, gl}, gates_exp());
    hcmd_n = 3'b111;
    lcmd = 3'b001;
    wait_clk(40);
    check({7'h00, gl[0]}, 8'h00);
    wait_clk(60);
    check({2'b00, gh, gl}, gates_exp());
    for (int k = 0; k < 20; k++) begin
      r = $random(seed);
      en = r[1:0] | {2{r[2]}};
      hcmd_n = r[5:3];
      lcmd = r[8:6];
      below = r[11:9];
      wait_clk(100);
      check({2'b00, gh, gl}, gates_exp());
      check({5'h00, lvl}, {5'h00, ~below});
    end
    // simultaneous mode: pins pass straight through and the dead time is skipped
    en = 2'b00;
    hcmd_n = 3'b111;
    lcmd = 3'b000;
    tpg_mcu_model_inst.xfer(8'h81, 8, rx);
    check(rx, {2'b00, dead});
    sim = 1'b1;
    en = 2'b11;
    hcmd_n = 3'b101;
    wait_clk(20);
    check({2'b00, gh, gl}, gates_exp());
    hcmd_n = 3'b111;
    lcmd = 3'b010;
    wait_clk(10);
    check({2'b00, gh, gl}, gates_exp());
    en = 2'b00;
    lcmd = 3'b000;
    tpg_mcu_model_inst.xfer(8'h80, 8, rx);
    check(rx, {2'b10, dead});
    sim = 1'b0;
    // reset in mid-run brings the dead time back to its reset value
    rst_n = 1'b0;
    wait_clk(3);
    rst_n = 1'b1;
    dead = `TPG_DEAD_RESET;
    wait_clk(4);
    check({7'h00, so_oe_n}, 8'h01);
    tpg_mcu_model_inst.xfer(8'h80, 8, rx);
    check(rx, {2'b00, dead});
    summarize();
  end
  initial begin
    #(10000 * 40);
    errors++;
    summarize();
  end
endmodule
